// [asppm_pkg.sv]
// Constants, field layouts and state types of the asynchronous serial port.
package asppm_pkg;

	////////////////////////////////////////////////////////////////////////////////////////
	// Register map (byte offsets, one 32-bit word each)
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_DATA = 8'h00;   // Write holding reg, read receive buffer
	localparam logic [7:0] OFS_CTRL = 8'h04;   // Character format and enables
	localparam logic [7:0] OFS_MCR = 8'h08;    // Modem control
	localparam logic [7:0] OFS_USR = 8'h0C;    // Status, error bits clear on read
	localparam logic [7:0] OFS_MSR = 8'h10;    // Modem status, deltas clear on read
	localparam logic [7:0] OFS_BAUD = 8'h14;   // Divisor and clock output select

	////////////////////////////////////////////////////////////////////////////////////////
	// Field positions and widths
	localparam int unsigned DATA_W = 8;        // Widest character
	localparam int unsigned DIV_W = 16;        // Baud divisor width
	localparam int unsigned BAUD_SEL_BIT = 7;  // Clock output select bit
	localparam int unsigned DIV_LSB = 8;       // Divisor field low bit
	localparam int unsigned CTRL_W = 7;
	localparam int unsigned MCR_W = 6;
	localparam int unsigned USR_W = 7;
	localparam logic [DIV_W-1:0] DIV_RST = 16'h0020;

	////////////////////////////////////////////////////////////////////////////////////////
	// Bit timing on the sixteen-times clock
	localparam int unsigned OVERSAMPLE = 16;
	localparam logic [3:0] TICK_LAST = 4'hF;   // Last tick of a bit period
	localparam logic [3:0] TICK_MID = 4'h7;    // Middle of the start bit
	localparam logic [3:0] MIN_BITS = 4'h5;    // Shortest character

	// Communication modes held in modem control
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_LOOP = 2'h1,
		MODE_ECHO = 2'h2,
		MODE_BREAK = 2'h3
	} asppm_mode_t;

	// Shared serial frame states, Gray coded along the frame
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_DATA = 3'h3,
		ST_PARITY = 3'h2,
		ST_STOP = 3'h6
	} asppm_state_t;

	// Character format register
	typedef struct packed {
		logic rx_en;
		logic tx_en;
		logic stop2;
		logic par_even;
		logic par_en;
		logic [1:0] len;
	} asppm_ctrl_t;

	// Modem control register
	typedef struct packed {
		logic dtr;
		logic rts;
		logic modem_irq_enable;
		logic irq_enable;
		asppm_mode_t mode;
	} asppm_mcr_t;

	// Status register
	typedef struct packed {
		logic brk;
		logic fe;
		logic oe;
		logic pe;
		logic tx_complete;
		logic tx_holding_empty;
		logic rx_data_ready;
	} asppm_usr_t;

	localparam asppm_ctrl_t CTRL_RST = '0;
	localparam asppm_mcr_t MCR_RST = '0;
	localparam asppm_usr_t USR_RST = 7'h06;   // Holding empty and complete set

	// Number of data bits from the length field
	function automatic logic [3:0] char_bits(input logic [1:0] len);
		return {2'h0, len} + MIN_BITS;
	endfunction

endpackage

// [asppm_baud.sv]
// Baud generator: sixteen-times enable pulse and the selectable clock output.
`timescale 1ns/1ps
module asppm_baud #(
	parameter int unsigned DIV_W = asppm_pkg::DIV_W
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [DIV_W-1:0] div_i,
	input wire logic sel_baud_i,
	output logic tick16_o,
	output logic clock_output_o
);

	logic [DIV_W-1:0] cnt_q;     // Half-period counter
	logic phase_q;               // Which half of the 16x period
	logic half;                  // Half period elapsed
	logic clk_q;                 // Clock output level

	////////////////////////////////////////////////////////////////////////////////////////
	// A divisor of zero behaves as one so the generator never stalls
	assign half = (cnt_q >= div_i) || (cnt_q == div_i - DIV_W'(1));

	// Half-period counter
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || half) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + DIV_W'(1);
		end
	end

	// Phase toggles every half period
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			phase_q <= 1'b0;
		end else if (half) begin
			phase_q <= ~phase_q;
		end
	end

	// Clock output: 16x square wave, or the system clock halved as the buffered source
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			clk_q <= 1'b0;
		end else if (!sel_baud_i || half) begin
			clk_q <= ~clk_q;
		end
	end

	assign tick16_o = half && phase_q;
	assign clock_output_o = clk_q;

endmodule // asppm_baud

// [asppm_top.sv]
// Asynchronous serial port with APB registers, modem lines and four modes.
// Functional notes
// - RTS low when its control bit is one
// - High line is mark, low is space
// - Pin ignored in loop mode and reset
// - Output at mark when idle, disabled, blocked
// - Baud generator clocks both; clock output selectable
// - Holding register takes five to eight bits
// - Double buffering allows back-to-back characters
// - Received character moves to receive buffer
// - Parity, overrun, framing, break are reported
// - Modem control: mode, enables, RTS, DTR
// - Modem status records changes and levels
// - Control sets format; status shows state
// - Normal mode never loops data
// - Break mode sends all-zero characters
// - Echo mode retransmits the serial input
// - Echo mode hides CPU characters
// - Loop mode routes transmitter to receiver
// - Clear-to-send false blocks new characters only
// - Data ready sets on receipt, clears on read
// - Bit zero goes first on the line
// - Reset idles port, clears control, sets empties
`timescale 1ns/1ps
module asppm_top #(
	parameter logic [asppm_pkg::DIV_W-1:0] DIV_DEFAULT = asppm_pkg::DIV_RST
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [asppm_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic serial_in_i,
	output logic serial_out_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	output logic rts_n_o,
	output logic dtr_n_o,
	output logic tx_holding_empty_o,
	output logic rx_data_ready_o,
	output logic clock_output_o
);

	////////////////////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam int unsigned DW = asppm_pkg::DATA_W;

	// Address decode shared by the write and read paths
	function automatic logic known_addr(input logic [asppm_pkg::ADDR_W-1:0] a);
		return a == asppm_pkg::OFS_DATA || a == asppm_pkg::OFS_CTRL ||
			a == asppm_pkg::OFS_MCR || a == asppm_pkg::OFS_USR ||
			a == asppm_pkg::OFS_MSR || a == asppm_pkg::OFS_BAUD;
	endfunction

	asppm_pkg::asppm_ctrl_t ctrl_q;            // Character format
	asppm_pkg::asppm_mcr_t modem_control_reg_q;
	asppm_pkg::asppm_usr_t uart_status_reg;    // Assembled status view
	logic [asppm_pkg::DIV_W-1:0] div_q;        // Baud divisor
	logic baud_sel_q;                          // Clock output source
	logic [31:0] prdata_q;                     // Registered read data

	logic [2:0] sin_q, cts_q, dsr_q;           // Two-stage synchronisers, [2] is last seen
	logic sin_s, cts_act, dsr_act;             // Synchronised levels (active true)
	logic dcts_q, ddsr_q;                      // Modem deltas

	logic wr_acc, rd_acc;                      // APB access strobes
	logic wr_data, rd_data, rd_usr, rd_msr;    // Register hits with side effects
	logic tick;                                // 16x enable

	// Transmitter
	logic [DW-1:0] tx_holding_reg_q;
	logic hold_full_q;
	logic [DW-1:0] tx_shift_q;
	logic tx_par_q;
	asppm_pkg::asppm_state_t tx_state_q;
	logic [3:0] tx_cnt_q;
	logic [3:0] tx_idx_q;
	logic tx_bit, tx_wire, tx_start, tx_bit_end, serial_out_q;
	logic [3:0] nbits;

	// Receiver
	asppm_pkg::asppm_state_t rx_state_q;
	logic [3:0] rx_cnt_q;
	logic [3:0] rx_idx_q;
	logic [DW-1:0] rx_shift_q;
	logic [DW-1:0] rx_buffer_reg_q;
	logic rx_par_q, rx_zero_q, rx_src, rx_sample, rx_done;
	logic dr_q, pe_q, oe_q, fe_q, brk_q, pe_hit, fe_hit, brk_hit;

	////////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: the second stage gives the level, the third detects changes

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sin_q <= 3'h7;
			cts_q <= 3'h7;
			dsr_q <= 3'h7;
		end else begin
			sin_q <= {sin_q[1:0], serial_in_i};
			cts_q <= {cts_q[1:0], cts_n_i};
			dsr_q <= {dsr_q[1:0], dsr_n_i};
		end
	end

	assign sin_s = sin_q[1];                   // High is mark
	assign cts_act = ~cts_q[1];
	assign dsr_act = ~dsr_q[1];

	////////////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup cycle

	assign pready_o = psel_i && penable_i;
	assign pslverr_o = pready_o && !known_addr(paddr_i);
	assign wr_acc = pready_o && pwrite_i && known_addr(paddr_i);
	assign rd_acc = pready_o && !pwrite_i && known_addr(paddr_i);
	assign wr_data = wr_acc && paddr_i == asppm_pkg::OFS_DATA;
	assign rd_data = rd_acc && paddr_i == asppm_pkg::OFS_DATA;
	assign rd_usr = rd_acc && paddr_i == asppm_pkg::OFS_USR;
	assign rd_msr = rd_acc && paddr_i == asppm_pkg::OFS_MSR;

	// Control registers; the port idles after reset until enabled
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= asppm_pkg::CTRL_RST;
			modem_control_reg_q <= asppm_pkg::MCR_RST;
			div_q <= DIV_DEFAULT;
			baud_sel_q <= 1'b0;
		end else if (wr_acc) begin
			case (paddr_i)
				asppm_pkg::OFS_CTRL: begin
					ctrl_q <= pwdata_i[asppm_pkg::CTRL_W-1:0];
				end
				asppm_pkg::OFS_MCR: begin
					modem_control_reg_q <= pwdata_i[asppm_pkg::MCR_W-1:0];
				end
				asppm_pkg::OFS_BAUD: begin
					baud_sel_q <= pwdata_i[asppm_pkg::BAUD_SEL_BIT];
					div_q <= pwdata_i[asppm_pkg::DIV_LSB +: asppm_pkg::DIV_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Status view; reserved bits read zero
	always_comb begin
		uart_status_reg = '0;
		uart_status_reg.rx_data_ready = dr_q;
		uart_status_reg.tx_holding_empty = !hold_full_q;
		uart_status_reg.tx_complete = !hold_full_q && tx_state_q == asppm_pkg::ST_IDLE;
		uart_status_reg.pe = pe_q;
		uart_status_reg.oe = oe_q;
		uart_status_reg.fe = fe_q;
		uart_status_reg.brk = brk_q;
	end

	// Read data registered while the master sits in its setup cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			prdata_q <= '0;
		end else if (psel_i && !penable_i) begin
			case (paddr_i)
				asppm_pkg::OFS_DATA: prdata_q <= {24'h0, rx_buffer_reg_q};
				asppm_pkg::OFS_CTRL: prdata_q <= {25'h0, ctrl_q};
				asppm_pkg::OFS_MCR: prdata_q <= {26'h0, modem_control_reg_q};
				asppm_pkg::OFS_USR: prdata_q <= {25'h0, uart_status_reg};
				asppm_pkg::OFS_MSR: prdata_q <= {28'h0, ddsr_q, dcts_q, dsr_act, cts_act};
				asppm_pkg::OFS_BAUD: prdata_q <= {8'h0, div_q, baud_sel_q, 7'h0};
				default: prdata_q <= '0;
			endcase
		end
	end

	assign prdata_o = prdata_q;

	////////////////////////////////////////////////////////////////////////////////////////
	// Modem lines

	// Deltas stick until read; a change in the read cycle still lands
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dcts_q <= 1'b0;
			ddsr_q <= 1'b0;
		end else begin
			dcts_q <= (cts_q[2] != cts_q[1]) || (dcts_q && !rd_msr);
			ddsr_q <= (dsr_q[2] != dsr_q[1]) || (ddsr_q && !rd_msr);
		end
	end

	// Outputs are the inverse of the control bits, high out of reset
	assign rts_n_o = ~modem_control_reg_q.rts;
	assign dtr_n_o = ~modem_control_reg_q.dtr;

	////////////////////////////////////////////////////////////////////////////////////////
	// Baud generator shared by both directions

	asppm_baud #(
		.DIV_W(asppm_pkg::DIV_W)
	) u_baud (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.div_i(div_q),
		.sel_baud_i(baud_sel_q),
		.tick16_o(tick),
		.clock_output_o(clock_output_o)
	);

	assign nbits = asppm_pkg::char_bits(ctrl_q.len);

	////////////////////////////////////////////////////////////////////////////////////////
	// Transmitter

	// New character only when enabled and clear-to-send, except in loop mode
	assign tx_start = hold_full_q && ctrl_q.tx_en &&
		(cts_act || modem_control_reg_q.mode == asppm_pkg::MODE_LOOP);
	assign tx_bit_end = tick && tx_cnt_q == asppm_pkg::TICK_LAST;

	// Holding register; a write in the transfer cycle keeps the new character
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hold_full_q <= 1'b0;
			tx_holding_reg_q <= '0;
		end else if (wr_data) begin
			hold_full_q <= 1'b1;
			tx_holding_reg_q <= pwdata_i[DW-1:0];
		end else if (tx_start && ((tx_state_q == asppm_pkg::ST_IDLE && tick) ||
			(tx_state_q == asppm_pkg::ST_STOP && tx_bit_end && !(ctrl_q.stop2 && tx_idx_q == 4'h0)))) begin
			hold_full_q <= 1'b0;
		end
	end

	// Frame sequencer; the next character follows the stop bit directly
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tx_state_q <= asppm_pkg::ST_IDLE;
			tx_cnt_q <= '0;
			tx_idx_q <= '0;
			tx_shift_q <= '0;
			tx_par_q <= 1'b0;
		end else begin
			if (tick) begin
				tx_cnt_q <= tx_cnt_q + 4'h1;
			end
			case (tx_state_q)
				asppm_pkg::ST_IDLE: begin
					// Start on a tick so the start bit is a full 16 ticks long
					if (tx_start && tick) begin
						// Unused upper bits are masked so parity covers the character only
						tx_shift_q <= tx_holding_reg_q & ~(8'hFF << nbits);
						tx_par_q <= ^(tx_holding_reg_q & ~(8'hFF << nbits)) ^ !ctrl_q.par_even;
						tx_cnt_q <= '0;
						tx_state_q <= asppm_pkg::ST_START;
					end
				end
				asppm_pkg::ST_START: begin
					if (tx_bit_end) begin
						tx_idx_q <= '0;
						tx_state_q <= asppm_pkg::ST_DATA;
					end
				end
				asppm_pkg::ST_DATA: begin
					if (tx_bit_end) begin
						tx_shift_q <= {1'b0, tx_shift_q[DW-1:1]};
						tx_idx_q <= tx_idx_q + 4'h1;
						if (tx_idx_q == nbits - 4'h1) begin
							tx_idx_q <= '0;
							tx_state_q <= ctrl_q.par_en ? asppm_pkg::ST_PARITY : asppm_pkg::ST_STOP;
						end
					end
				end
				asppm_pkg::ST_PARITY: begin
					if (tx_bit_end) begin
						tx_state_q <= asppm_pkg::ST_STOP;
					end
				end
				asppm_pkg::ST_STOP: begin
					if (tx_bit_end) begin
						if (ctrl_q.stop2 && tx_idx_q == 4'h0) begin
							tx_idx_q <= 4'h1;
						end else if (tx_start) begin
							tx_shift_q <= tx_holding_reg_q & ~(8'hFF << nbits);
							tx_par_q <= ^(tx_holding_reg_q & ~(8'hFF << nbits)) ^ !ctrl_q.par_even;
							tx_state_q <= asppm_pkg::ST_START;
						end else begin
							tx_state_q <= asppm_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					tx_state_q <= asppm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Line level per frame position; break mode zeroes every position
	always_comb begin
		case (tx_state_q)
			asppm_pkg::ST_START: tx_bit = 1'b0;
			asppm_pkg::ST_DATA: tx_bit = tx_shift_q[0];
			asppm_pkg::ST_PARITY: tx_bit = tx_par_q;
			default: tx_bit = 1'b1;
		endcase
		if (modem_control_reg_q.mode == asppm_pkg::MODE_BREAK) begin
			tx_bit = tx_bit && tx_state_q == asppm_pkg::ST_IDLE;
		end
	end

	// Idle or disabled transmitter shows mark
	assign tx_wire = (ctrl_q.tx_en && tx_state_q != asppm_pkg::ST_IDLE) ? tx_bit : 1'b1;

	// Pin mux: echo passes the input, loop keeps mark, normal never loops
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			serial_out_q <= 1'b1;
		end else begin
			case (modem_control_reg_q.mode)
				asppm_pkg::MODE_ECHO: serial_out_q <= sin_s;
				asppm_pkg::MODE_LOOP: serial_out_q <= 1'b1;
				default: serial_out_q <= tx_wire;
			endcase
		end
	end

	assign serial_out_o = serial_out_q;
	assign tx_holding_empty_o = !hold_full_q;

	////////////////////////////////////////////////////////////////////////////////////////
	// Receiver

	// Loop mode feeds the transmitter in and ignores the pin
	assign rx_src = (modem_control_reg_q.mode == asppm_pkg::MODE_LOOP) ? tx_wire : sin_s;
	assign rx_sample = tick && rx_cnt_q == asppm_pkg::TICK_LAST;

	// Frame sequencer: start confirmed at mid bit, then one sample per 16 ticks
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rx_state_q <= asppm_pkg::ST_IDLE;
			rx_cnt_q <= '0;
			rx_idx_q <= '0;
			rx_shift_q <= '0;
			rx_par_q <= 1'b0;
			rx_zero_q <= 1'b0;
		end else begin
			if (tick) begin
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
			case (rx_state_q)
				asppm_pkg::ST_IDLE: begin
					rx_cnt_q <= '0;
					if (ctrl_q.rx_en && tick && !rx_src) begin
						rx_state_q <= asppm_pkg::ST_START;
					end
				end
				asppm_pkg::ST_START: begin
					if (tick && rx_cnt_q == asppm_pkg::TICK_MID) begin
						rx_cnt_q <= '0;
						rx_idx_q <= '0;
						rx_par_q <= 1'b0;
						rx_zero_q <= 1'b1;
						// A glitch shorter than half a bit is dropped
						rx_state_q <= rx_src ? asppm_pkg::ST_IDLE : asppm_pkg::ST_DATA;
					end
				end
				asppm_pkg::ST_DATA: begin
					if (rx_sample) begin
						rx_shift_q <= {rx_src, rx_shift_q[DW-1:1]};
						rx_par_q <= rx_par_q ^ rx_src;
						rx_zero_q <= rx_zero_q && !rx_src;
						rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_idx_q == nbits - 4'h1) begin
							rx_state_q <= ctrl_q.par_en ? asppm_pkg::ST_PARITY : asppm_pkg::ST_STOP;
						end
					end
				end
				asppm_pkg::ST_PARITY: begin
					if (rx_sample) begin
						rx_par_q <= rx_par_q ^ rx_src;
						rx_zero_q <= rx_zero_q && !rx_src;
						rx_state_q <= asppm_pkg::ST_STOP;
					end
				end
				asppm_pkg::ST_STOP: begin
					if (rx_sample) begin
						rx_state_q <= asppm_pkg::ST_IDLE;
					end
				end
				default: begin
					rx_state_q <= asppm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Completion and error results at the stop bit sample
	assign rx_done = rx_state_q == asppm_pkg::ST_STOP && rx_sample;
	assign brk_hit = rx_done && rx_zero_q && !rx_src;
	assign fe_hit = rx_done && !rx_src && !brk_hit;
	assign pe_hit = rx_done && ctrl_q.par_en && (rx_par_q != !ctrl_q.par_even);

	// Receive buffer, right-aligned to the character length
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rx_buffer_reg_q <= '0;
		end else if (rx_done) begin
			rx_buffer_reg_q <= rx_shift_q >> (4'h8 - nbits);
		end
	end

	// Data ready: a new character wins over a read in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dr_q <= 1'b0;
		end else begin
			dr_q <= rx_done || (dr_q && !rd_data);
		end
	end

	assign rx_data_ready_o = dr_q;

	// Error flags stick until status is read; a new error wins over the read
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pe_q <= 1'b0;
			oe_q <= 1'b0;
			fe_q <= 1'b0;
			brk_q <= 1'b0;
		end else begin
			pe_q <= pe_hit || (pe_q && !rd_usr);
			oe_q <= (rx_done && dr_q && !rd_data) || (oe_q && !rd_usr);
			fe_q <= fe_hit || (fe_q && !rd_usr);
			brk_q <= brk_hit || (brk_q && !rd_usr);
		end
	end

endmodule // asppm_top

// [asppm_sva.sv]
// Checker of register, modem line and serial pin behaviour at the port's pins.
`timescale 1ns/1ps
module asppm_sva (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [asppm_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic serial_out_o,
	input wire logic rts_n_o,
	input wire logic dtr_n_o,
	input wire logic tx_holding_empty_o,
	input wire logic rx_data_ready_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic acc; // Access edge of any transfer
	logic loop_q; // Loop mode as last written
	assign acc = psel_i & penable_i;
	////////////////////////////////////////////////////////////////////////////////
	// Mirror of the mode field, needed because the pin gating depends on it
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			loop_q <= 1'b0;
		end else if (acc && pwrite_i && paddr_i == asppm_pkg::OFS_MCR) begin
			loop_q <= pwdata_i[1:0] == 2'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_rts;
		acc && pwrite_i && paddr_i == asppm_pkg::OFS_MCR |=> rts_n_o == !$past(pwdata_i[4]);
	endproperty
	a_rts: assert property (p_rts) else $error("rts level wrong");
	property p_dtr;
		acc && pwrite_i && paddr_i == asppm_pkg::OFS_MCR |=> dtr_n_o == !$past(pwdata_i[5]);
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr level wrong");
	// Reset itself is the cause here, so it must not disable the check
	property p_rst;
		disable iff (1'b0) sys_rst_i |=> serial_out_o && rts_n_o && dtr_n_o
			&& tx_holding_empty_o && !rx_data_ready_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_rdy;
		pready_o == acc;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready wrong");
	property p_err;
		acc && paddr_i > asppm_pkg::OFS_BAUD |-> pslverr_o;
	endproperty
	a_err: assert property (p_err) else $error("no error on unmapped");
	property p_thr_clr;
		acc && pwrite_i && paddr_i == asppm_pkg::OFS_DATA |=> !tx_holding_empty_o;
	endproperty
	a_thr_clr: assert property (p_thr_clr) else $error("empty not cleared");
	property p_thr_fell;
		$fell(tx_holding_empty_o) |-> $past(acc && pwrite_i && paddr_i == asppm_pkg::OFS_DATA);
	endproperty
	a_thr_fell: assert property (p_thr_fell) else $error("empty fell alone");
	property p_dr_clr;
		acc && !pwrite_i && paddr_i == asppm_pkg::OFS_DATA |=> !rx_data_ready_o;
	endproperty
	a_dr_clr: assert property (p_dr_clr) else $error("ready not cleared");
	property p_loop;
		loop_q && $past(loop_q) |-> serial_out_o;
	endproperty
	a_loop: assert property (p_loop) else $error("pin active in loop");
endmodule // asppm_sva

// [asppm_peer.sv]
// Remote serial station: sends frames to the port and decodes its output.
`timescale 1ns/1ps
module asppm_peer #(
	parameter int BIT = 32 // Clocks per bit at divisor one
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o,
	output logic cts_n_o,
	output logic dsr_n_o
);
	logic [7:0] got [4]; // Decoded characters
	int n_got = 0;
	int cyc = 0;
	int start_q = 0;
	int gap = 0; // Clocks between the last two start edges
	initial begin
		line_o = 1'b1; // Idle line is mark
		cts_n_o = 1'b0;
		dsr_n_o = 1'b1;
	end
	always @(posedge clk_i) cyc++;
	////////////////////////////////////////////////////////////////////////////////
	// Start, eight data bits first bit lowest, then stop level f[8]
	task automatic send(input logic [8:0] f);
		line_o <= 1'b0;
		repeat (BIT) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			line_o <= f[i];
			repeat (BIT) @(posedge clk_i);
		end
		line_o <= 1'b1;
	endtask
	// Decoder, sampling at mid-bit to stay clear of edges
	always begin
		@(negedge line_i);
		gap = cyc - start_q;
		start_q = cyc;
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_i);
			got[n_got % 4][i] = line_i;
		end
		repeat (BIT) @(posedge clk_i);
		n_got++;
	end
endmodule // asppm_peer

// [asppm_tb.sv]
// Self-checking bench of the serial port against the remote station model.
`timescale 1ns/1ps
module testbench;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic s_in, s_out, cts_n, dsr_n, rts_n, dtr_n, thr_e, dr, clk_out;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int n_errors = 0;
	int checks = 0;
	asppm_top u_dut (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .serial_in_i(s_in), .serial_out_o(s_out),
		.cts_n_i(cts_n), .dsr_n_i(dsr_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
		.tx_holding_empty_o(thr_e), .rx_data_ready_o(dr), .clock_output_o(clk_out));
	asppm_peer u_peer (.clk_i(clk), .line_i(s_out), .line_o(s_in), .cts_n_o(cts_n),
		.dsr_n_o(dsr_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic tmo();
		n_errors++;
		$display("BAD wait exp done got timeout");
		end_sim();
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	// One APB transfer; no wait count assumed, only a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) tmo();
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Bounded wait: 0 data ready, 1 holding empty, 2 two characters seen
	task automatic wait_for(input int sel);
		int n;
		n = 0;
		while (!(sel == 0 ? dr === 1'b1 : sel == 1 ? thr_e === 1'b1 : u_peer.n_got == 2)) begin
			@(posedge clk);
			n++;
			if (n > 3000) tmo();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		@(negedge clk);
		chk("idle pins", 5'h1D, {s_out, rts_n, dtr_n, dr, thr_e});
		rd = {31'h0, clk_out};
		@(negedge clk);
		chk("clock out", rd ^ 32'h1, clk_out);
		apb(1'b0, asppm_pkg::OFS_USR, 32'h0);
		chk("status", 32'h6, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("t_reset done");
	endtask
	task automatic t_mcr();
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h30);
		@(negedge clk);
		chk("modem on", 2'h0, {rts_n, dtr_n});
		apb(1'b0, asppm_pkg::OFS_MCR, 32'h0);
		chk("mcr", 32'h30, rd);
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h0);
		@(negedge clk);
		chk("modem off", 2'h3, {rts_n, dtr_n});
		$display("t_mcr done");
	endtask
	task automatic t_tx();
		apb(1'b1, asppm_pkg::OFS_BAUD, 32'h100);
		apb(1'b1, asppm_pkg::OFS_CTRL, 32'h63);
		apb(1'b1, asppm_pkg::OFS_DATA, 32'hA5);
		@(negedge clk);
		chk("empty", 1'b0, thr_e);
		wait_for(1);
		apb(1'b1, asppm_pkg::OFS_DATA, 32'h13C);
		wait_for(2);
		chk("tx first", 8'hA5, u_peer.got[0]);
		chk("tx second", 8'h3C, u_peer.got[1]);
		chk("no gap", 1'b1, u_peer.gap >= 320 && u_peer.gap <= 324);
		$display("t_tx done");
	endtask
	task automatic t_rx();
		u_peer.send(9'h196);
		wait_for(0);
		apb(1'b0, asppm_pkg::OFS_DATA, 32'h0);
		chk("rx char", 32'h96, rd);
		@(negedge clk);
		chk("ready off", 1'b0, dr);
		u_peer.send(9'h000);
		wait_for(0);
		apb(1'b0, asppm_pkg::OFS_USR, 32'h0);
		chk("break flag", 32'h47, rd);
		apb(1'b0, asppm_pkg::OFS_DATA, 32'h0);
		chk("break char", 32'h0, rd);
		$display("t_rx done");
	endtask
	task automatic t_loop();
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h1);
		apb(1'b1, asppm_pkg::OFS_DATA, 32'h5A);
		wait_for(0);
		apb(1'b0, asppm_pkg::OFS_DATA, 32'h0);
		chk("loop char", 32'h5A, rd);
		chk("pin quiet", 32'h2, u_peer.n_got);
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h0);
		$display("t_loop done");
	endtask
	task automatic t_modes();
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h3);
		apb(1'b1, asppm_pkg::OFS_DATA, 32'hFF);
		repeat (400) @(posedge clk);
		chk("brk count", 32'h3, u_peer.n_got);
		chk("brk tx", 8'h00, u_peer.got[2]);
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h2);
		apb(1'b1, asppm_pkg::OFS_DATA, 32'h11);
		u_peer.send(9'h1C3);
		repeat (40) @(posedge clk);
		chk("echo char", 8'hC3, u_peer.got[3]);
		chk("echo count", 32'h4, u_peer.n_got);
		apb(1'b1, asppm_pkg::OFS_MCR, 32'h0);
		$display("t_modes done");
	endtask
	task automatic t_msr();
		apb(1'b0, asppm_pkg::OFS_MSR, 32'h0);
		u_peer.dsr_n_o <= 1'b0;
		repeat (6) @(posedge clk);
		apb(1'b0, asppm_pkg::OFS_MSR, 32'h0);
		chk("msr delta", 32'hB, rd);
		apb(1'b0, asppm_pkg::OFS_MSR, 32'h0);
		chk("msr level", 32'h3, rd);
		$display("t_msr done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_mcr();
		t_tx();
		t_rx();
		t_loop();
		t_modes();
		t_msr();
		end_sim();
	end
endmodule // testbench
bind asppm_top asppm_sva u_sva (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .serial_out_o(serial_out_o), .rts_n_o(rts_n_o),
	.dtr_n_o(dtr_n_o), .tx_holding_empty_o(tx_holding_empty_o),
	.rx_data_ready_o(rx_data_ready_o));
